// ---- host_port_pkg.sv ----
/*
 Constants for the dual-channel host slave port: slave-side register
 addresses, field positions, reset values.
 Assumes a 16-bit slave CPU address bus with 8-bit data.
*/
package host_port_pkg;
   localparam logic [15:0] ADDR_SERIAL_TIMER_CONTROL = 16'hFFC3;
   localparam logic [15:0] ADDR_SYSTEM_CONTROL       = 16'hFFC4;
   localparam logic [15:0] ADDR_HOST_PORT_CONTROL    = 16'hFFF0;
   localparam logic [15:0] ADDR_CHAN1_INPUT_DATA     = 16'hFFF4;
   localparam logic [15:0] ADDR_CHAN1_OUTPUT_DATA    = 16'hFFF5;
   localparam logic [15:0] ADDR_CHAN1_STATUS         = 16'hFFF6;
   localparam logic [15:0] ADDR_CHAN2_INPUT_DATA     = 16'hFFFC;
   localparam logic [15:0] ADDR_CHAN2_OUTPUT_DATA    = 16'hFFFD;
   localparam logic [15:0] ADDR_CHAN2_STATUS         = 16'hFFFE;
   localparam logic [11:0] UPPER_RANGE_BASE          = 12'hFFF;
   localparam logic [7:0]  RESET_SERIAL_TIMER        = 8'h00;
   localparam logic [7:0]  RESET_SYSTEM_CONTROL      = 8'h09;
   localparam logic [7:0]  RESET_HOST_PORT_CONTROL   = 8'hF8;
   localparam logic [7:0]  RESET_STATUS              = 8'h00;
   localparam logic [7:0]  SYSCTL_WRITE_MASK         = 8'hF7;
   localparam logic [7:0]  STATUS_USER_MASK          = 8'hF4;
   localparam logic [7:0]  CONTROL_FIXED_ONES        = 8'hF8;
   localparam int          BIT_HOST_PORT_ENABLE      = 1;
   localparam int          BIT_FAST_GATE_ENABLE      = 0;
   localparam int          BIT_CHAN1_IRQ_ENABLE      = 1;
   localparam int          BIT_CHAN2_IRQ_ENABLE      = 2;
   localparam int          BIT_COMMAND_DATA          = 3;
   localparam int          BIT_INPUT_FULL            = 1;
   localparam int          BIT_OUTPUT_FULL           = 0;
endpackage : host_port_pkg

// ---- host_pin_sync.sv ----
/*
 Two-flop synchroniser for a bundle of host pins.
 Assumes inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module host_pin_sync #(
   parameter int WIDTH = 12
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] idle_value,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // Both flops hold each pin relative to its idle level, so the all-ones
   // reset means idle and no false strobe edge follows reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= '1;
         stage2 <= '1;
      end else begin
         stage1 <= async_in ^ ~idle_value;
         stage2 <= stage1;
      end
   end

   assign sync_out = stage2 ^ ~idle_value;
endmodule : host_pin_sync
`default_nettype wire

// ---- host_slave_port.sv ----
/*
 Dual-channel host slave port: host pin side and slave CPU register side.
 Assumes the slave bus gives one-cycle rd/wr strobes with stable address,
 and that the standby input is a level from the chip's power control.
*/
`timescale 1ns/1ps
`default_nettype none
module host_slave_port (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        standby,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_rd,
   input  wire logic        cpu_wr,
   input  wire logic [7:0]  cpu_wdata,
   output logic      [7:0]  cpu_rdata,
   output logic             cpu_hit,
   input  wire logic        chan1_select_n,
   input  wire logic        chan2_select_n,
   input  wire logic        command_data_line,
   input  wire logic        host_read_strobe_n,
   input  wire logic        host_write_strobe_n,
   input  wire logic [7:0]  host_data_bus_in,
   output logic      [7:0]  host_data_bus_out,
   output logic             host_data_bus_oe_n,
   output logic             chan1_input_full_irq,
   output logic             chan2_input_full_irq,
   output logic             fast_gate_enable,
   output logic             host_port_enable
);
   logic [7:0] serial_timer_control;
   logic [7:0] system_control;
   logic [7:0] host_port_control;
   logic [7:0] chan1_input_data;
   logic [7:0] chan1_output_data;
   logic [7:0] chan1_status;
   logic [7:0] chan2_input_data;
   logic [7:0] chan2_output_data;
   logic [7:0] chan2_status;
   logic [12:0] pins_sync;
   logic [12:0] pins_raw;
   logic       s_sel1_n, s_sel2_n, s_a0, s_rd_n, s_wr_n;
   logic [7:0] s_data;
   logic       wr_prev, rd_prev;
   logic       host_wr_rise, host_rd_rise;
   logic       sel1_q, sel2_q, a0_q;
   logic       upper_ok;
   logic       slv_rd, slv_wr;

   assign pins_raw = {chan1_select_n, chan2_select_n, command_data_line,
                      host_read_strobe_n, host_write_strobe_n, host_data_bus_in};

   host_pin_sync #(.WIDTH(13)) u_sync (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .async_in   (pins_raw),
      .idle_value ({5'h1B, 8'hFF}),
      .sync_out   (pins_sync)
   );

   assign {s_sel1_n, s_sel2_n, s_a0, s_rd_n, s_wr_n, s_data} = pins_sync;
   assign host_port_enable = system_control[host_port_pkg::BIT_HOST_PORT_ENABLE];
   assign fast_gate_enable = host_port_control[host_port_pkg::BIT_FAST_GATE_ENABLE];

   // Address, select and data are held stable across the strobe, so the
   // values of the previous cycle are those seen at the rising edge.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_prev <= 1'b1;
         rd_prev <= 1'b1;
         sel1_q  <= 1'b1;
         sel2_q  <= 1'b1;
         a0_q    <= 1'b0;
      end else begin
         wr_prev <= s_wr_n;
         rd_prev <= s_rd_n;
         sel1_q  <= s_sel1_n;
         sel2_q  <= s_sel2_n;
         a0_q    <= s_a0;
      end
   end

   // One pulse per strobe rise while the port is enabled: each host access acts once, or not at all while the port is off
   assign host_wr_rise = s_wr_n & ~wr_prev & host_port_enable;
   assign host_rd_rise = s_rd_n & ~rd_prev & host_port_enable;

   assign upper_ok = (cpu_addr[15:4] != host_port_pkg::UPPER_RANGE_BASE) || host_port_enable;
   assign slv_rd   = cpu_rd & upper_ok;
   assign slv_wr   = cpu_wr & upper_ok;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         serial_timer_control <= host_port_pkg::RESET_SERIAL_TIMER;
         system_control       <= host_port_pkg::RESET_SYSTEM_CONTROL;
         host_port_control    <= host_port_pkg::RESET_HOST_PORT_CONTROL;
      end else if (standby) begin
         serial_timer_control <= host_port_pkg::RESET_SERIAL_TIMER;
         system_control       <= host_port_pkg::RESET_SYSTEM_CONTROL;
         host_port_control    <= host_port_pkg::RESET_HOST_PORT_CONTROL;
      end else if (slv_wr) begin
         if (cpu_addr == host_port_pkg::ADDR_SERIAL_TIMER_CONTROL) begin
            serial_timer_control <= cpu_wdata;
         end
         if (cpu_addr == host_port_pkg::ADDR_SYSTEM_CONTROL) begin
            system_control <= (cpu_wdata & host_port_pkg::SYSCTL_WRITE_MASK)
                            | (system_control & ~host_port_pkg::SYSCTL_WRITE_MASK);
         end
         if (cpu_addr == host_port_pkg::ADDR_HOST_PORT_CONTROL) begin
            host_port_control <= cpu_wdata | host_port_pkg::CONTROL_FIXED_ONES;
         end
      end
   end

   // Data registers carry no reset; contents start undefined
   always_ff @(posedge clk_sys) begin
      if (host_wr_rise && !sel1_q) begin
         chan1_input_data <= s_data;
      end
      if (host_wr_rise && !sel2_q) begin
         chan2_input_data <= s_data;
      end
      if (slv_wr && cpu_addr == host_port_pkg::ADDR_CHAN1_OUTPUT_DATA) begin
         chan1_output_data <= cpu_wdata;
      end
      if (slv_wr && cpu_addr == host_port_pkg::ADDR_CHAN2_OUTPUT_DATA) begin
         chan2_output_data <= cpu_wdata;
      end
   end

   function automatic logic [7:0] next_status(
      input logic [7:0] cur,
      input logic       user_wr,
      input logic [7:0] wdata,
      input logic       host_wr,
      input logic       cmd,
      input logic       in_read,
      input logic       out_write,
      input logic       host_rd
   );
      logic [7:0] v;
      v = cur;
      if (user_wr) begin
         v = (wdata & host_port_pkg::STATUS_USER_MASK) | (cur & ~host_port_pkg::STATUS_USER_MASK);
      end
      if (in_read) begin
         v[host_port_pkg::BIT_INPUT_FULL] = 1'b0;
      end
      // Set after clear so a same-cycle host write is not lost
      if (host_wr) begin
         v[host_port_pkg::BIT_INPUT_FULL]   = 1'b1;
         v[host_port_pkg::BIT_COMMAND_DATA] = cmd;
      end
      if (host_rd) begin
         v[host_port_pkg::BIT_OUTPUT_FULL] = 1'b0;
      end
      if (out_write) begin
         v[host_port_pkg::BIT_OUTPUT_FULL] = 1'b1;
      end
      return v;
   endfunction : next_status

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         chan1_status <= host_port_pkg::RESET_STATUS;
         chan2_status <= host_port_pkg::RESET_STATUS;
      end else if (standby) begin
         chan1_status <= host_port_pkg::RESET_STATUS;
         chan2_status <= host_port_pkg::RESET_STATUS;
      end else begin
         chan1_status <= next_status(chan1_status,
            slv_wr && cpu_addr == host_port_pkg::ADDR_CHAN1_STATUS, cpu_wdata,
            host_wr_rise && !sel1_q, a0_q,
            slv_rd && cpu_addr == host_port_pkg::ADDR_CHAN1_INPUT_DATA,
            slv_wr && cpu_addr == host_port_pkg::ADDR_CHAN1_OUTPUT_DATA,
            host_rd_rise && !sel1_q && !a0_q);
         chan2_status <= next_status(chan2_status,
            slv_wr && cpu_addr == host_port_pkg::ADDR_CHAN2_STATUS, cpu_wdata,
            host_wr_rise && !sel2_q, a0_q,
            slv_rd && cpu_addr == host_port_pkg::ADDR_CHAN2_INPUT_DATA,
            slv_wr && cpu_addr == host_port_pkg::ADDR_CHAN2_OUTPUT_DATA,
            host_rd_rise && !sel2_q && !a0_q);
      end
   end

   assign chan1_input_full_irq = chan1_status[host_port_pkg::BIT_INPUT_FULL]
                               & host_port_control[host_port_pkg::BIT_CHAN1_IRQ_ENABLE];
   assign chan2_input_full_irq = chan2_status[host_port_pkg::BIT_INPUT_FULL]
                               & host_port_control[host_port_pkg::BIT_CHAN2_IRQ_ENABLE];

   // Slave read mux; input data is readable but never writable
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cpu_rdata <= 8'h00;
         cpu_hit   <= 1'b0;
      end else begin
         cpu_rdata <= 8'h00;
         cpu_hit   <= 1'b0;
         if (cpu_rd && upper_ok) begin
            cpu_hit <= 1'b1;
            unique case (cpu_addr)
               host_port_pkg::ADDR_SERIAL_TIMER_CONTROL: cpu_rdata <= serial_timer_control;
               host_port_pkg::ADDR_SYSTEM_CONTROL:       cpu_rdata <= system_control;
               host_port_pkg::ADDR_HOST_PORT_CONTROL:    cpu_rdata <= host_port_control;
               host_port_pkg::ADDR_CHAN1_INPUT_DATA:     cpu_rdata <= chan1_input_data;
               host_port_pkg::ADDR_CHAN1_OUTPUT_DATA:    cpu_rdata <= chan1_output_data;
               host_port_pkg::ADDR_CHAN1_STATUS:         cpu_rdata <= chan1_status;
               host_port_pkg::ADDR_CHAN2_INPUT_DATA:     cpu_rdata <= chan2_input_data;
               host_port_pkg::ADDR_CHAN2_OUTPUT_DATA:    cpu_rdata <= chan2_output_data;
               host_port_pkg::ADDR_CHAN2_STATUS:         cpu_rdata <= chan2_status;
               default:                                  cpu_hit   <= 1'b0;
            endcase
         end
      end
   end

   // Host read data from flops; enable is combinational on synced pins
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         host_data_bus_out <= 8'h00;
      end else if (!s_sel1_n) begin
         host_data_bus_out <= s_a0 ? chan1_status : chan1_output_data;
      end else begin
         host_data_bus_out <= s_a0 ? chan2_status : chan2_output_data;
      end
   end

   assign host_data_bus_oe_n = ~(host_port_enable & ~s_rd_n & (s_sel1_n ^ s_sel2_n));
endmodule : host_slave_port
`default_nettype wire

// ---- host_port_checker.sv ----
/* Assertion checker for host_slave_port, bound to its ports.
   Assumes one-cycle slave strobes and registered read data. */
`timescale 1ns/1ps
`default_nettype none
module host_port_checker (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        standby,
   input wire logic [15:0] cpu_addr,
   input wire logic        cpu_rd,
   input wire logic        cpu_wr,
   input wire logic [7:0]  cpu_wdata,
   input wire logic [7:0]  cpu_rdata,
   input wire logic        cpu_hit,
   input wire logic        host_read_strobe_n,
   input wire logic        host_data_bus_oe_n,
   input wire logic        chan1_input_full_irq,
   input wire logic        chan2_input_full_irq,
   input wire logic        fast_gate_enable,
   input wire logic        host_port_enable
);
   localparam logic [15:0] CTL = host_port_pkg::ADDR_HOST_PORT_CONTROL;
   localparam logic [15:0] IN1 = host_port_pkg::ADDR_CHAN1_INPUT_DATA;
   logic wr_ctl;
   assign wr_ctl = cpu_wr && cpu_addr == CTL && host_port_enable;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_window;
      cpu_rd && cpu_addr[15:4] == 12'hFFF && !host_port_enable |=> !cpu_hit && cpu_rdata == 8'h00;
   endproperty
   a_window: assert property (p_window) else $error("refused read answered");
   property p_idle_bus; !host_port_enable |-> host_data_bus_oe_n; endproperty
   a_idle_bus: assert property (p_idle_bus) else $error("bus driven while off");
   property p_standby; standby |=> !host_port_enable && !fast_gate_enable; endproperty
   a_standby: assert property (p_standby) else $error("standby kept enables");
   property p_ones; cpu_rd && cpu_addr == CTL && host_port_enable |=> cpu_hit && cpu_rdata[7:3] == 5'h1F; endproperty
   a_ones: assert property (p_ones) else $error("control upper bits wrong");
   // Two cycles allowed: the request level may be registered behind the enable
   property p_irq2_mask; wr_ctl && !cpu_wdata[2] |-> ##2 !chan2_input_full_irq; endproperty
   a_irq2_mask: assert property (p_irq2_mask) else $error("irq2 not masked");
   property p_irq1_mask; wr_ctl && !cpu_wdata[1] |-> ##2 !chan1_input_full_irq; endproperty
   a_irq1_mask: assert property (p_irq1_mask) else $error("irq1 not masked");
   property p_gate; wr_ctl |=> fast_gate_enable == $past(cpu_wdata[0]); endproperty
   a_gate: assert property (p_gate) else $error("gate enable wrong");
   property p_drive; $fell(host_data_bus_oe_n) |-> !host_read_strobe_n; endproperty
   a_drive: assert property (p_drive) else $error("bus driven without read");
   property p_clear; cpu_rd && cpu_addr == IN1 && host_port_enable |-> ##2 !chan1_input_full_irq; endproperty
   a_clear: assert property (p_clear) else $error("input full not cleared");
   c_hit: cover property (cpu_hit);
   c_host_read: cover property ($fell(host_data_bus_oe_n));
   c_irq: cover property ($rose(chan1_input_full_irq));
endmodule : host_port_checker
bind host_slave_port host_port_checker chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .standby(standby), .cpu_addr(cpu_addr),
   .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
   .cpu_hit(cpu_hit), .host_read_strobe_n(host_read_strobe_n), .host_data_bus_oe_n(host_data_bus_oe_n),
   .chan1_input_full_irq(chan1_input_full_irq), .chan2_input_full_irq(chan2_input_full_irq),
   .fast_gate_enable(fast_gate_enable), .host_port_enable(host_port_enable));
`default_nettype wire

// ---- host_model.sv ----
/* Host processor model on the port's host pins.
   Assumes one access at a time, paced by the caller. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] dev_out,
   input  wire logic       dev_oe_n,
   output logic            sel1_n,
   output logic            sel2_n,
   output logic            cmd,
   output logic            rd_n,
   output logic            wr_n,
   output logic      [7:0] bus
);
   logic [7:0] drv    = 8'h00;
   logic [7:0] last   = 8'h00;
   logic       drv_on = 1'b0;
   // An undriven bus flips every cycle so stale data never passes for a read
   assign bus = !dev_oe_n ? dev_out : drv_on ? drv : ~last;
   always @(posedge clk_sys) last <= bus;
   initial begin
      sel1_n = 1'b1;
      sel2_n = 1'b1;
      cmd = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
   end
   // Strobe low six cycles, pins held four after its rise: twice the sync needs
   task automatic access(input logic ch, c, w, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_sys);
      sel1_n = ch;
      sel2_n = !ch;
      cmd = c;
      drv = d;
      drv_on = w;
      repeat (2) @(negedge clk_sys);
      rd_n = w;
      wr_n = !w;
      repeat (6) @(negedge clk_sys);
      q = bus;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      sel1_n = 1'b1;
      sel2_n = 1'b1;
      drv_on = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask : access
endmodule : host_model
`default_nettype wire

// ---- testbench.sv ----
/* Self-checking bench for host_slave_port with a host model.
   Assumes the package, design and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct packed {logic w; logic [15:0] a; logic [7:0] d; logic [7:0] e; logic h;} row_t;
   logic        clk_sys   = 1'b0;
   logic        reset_n   = 1'b0;
   logic        standby   = 1'b0;
   logic [15:0] cpu_addr  = 16'h0000;
   logic        cpu_rd    = 1'b0;
   logic        cpu_wr    = 1'b0;
   logic [7:0]  cpu_wdata = 8'h00;
   logic [7:0]  cpu_rdata, hout, bus, q;
   logic        cpu_hit, oe_n, irq1, irq2, fge, hpe, s1, s2, cd, rdn, wrn, h;
   int          err_count = 0;
   int          n_checks  = 0;
   int          cycles    = 0;
   row_t rows [24] = '{
      '{1'b0, 16'hFFF0, 8'h00, 8'h00, 1'b0}, '{1'b0, 16'hFFC4, 8'h00, 8'h09, 1'b1},
      '{1'b1, 16'hFFC3, 8'hA5, 8'h00, 1'b0}, '{1'b0, 16'hFFC3, 8'h00, 8'hA5, 1'b1},
      '{1'b1, 16'hFFC4, 8'h03, 8'h00, 1'b0}, '{1'b0, 16'hFFC4, 8'h00, 8'h0B, 1'b1},
      '{1'b0, 16'hFFF0, 8'h00, 8'hF8, 1'b1}, '{1'b1, 16'hFFF0, 8'h00, 8'h00, 1'b0},
      '{1'b0, 16'hFFF0, 8'h00, 8'hF8, 1'b1}, '{1'b1, 16'hFFF0, 8'h07, 8'h00, 1'b0},
      '{1'b0, 16'hFFF0, 8'h00, 8'hFF, 1'b1}, '{1'b1, 16'hFFF6, 8'hFF, 8'h00, 1'b0},
      '{1'b0, 16'hFFF6, 8'h00, 8'hF4, 1'b1}, '{1'b1, 16'hFFFE, 8'hFF, 8'h00, 1'b0},
      '{1'b0, 16'hFFFE, 8'h00, 8'hF4, 1'b1}, '{1'b1, 16'hFFF6, 8'h00, 8'h00, 1'b0},
      '{1'b1, 16'hFFFE, 8'h00, 8'h00, 1'b0}, '{1'b0, 16'hFFF8, 8'h00, 8'h00, 1'b0},
      '{1'b1, 16'hFFF5, 8'h3C, 8'h00, 1'b0}, '{1'b0, 16'hFFF5, 8'h00, 8'h3C, 1'b1},
      '{1'b0, 16'hFFF6, 8'h00, 8'h01, 1'b1}, '{1'b1, 16'hFFFD, 8'hC3, 8'h00, 1'b0},
      '{1'b0, 16'hFFFD, 8'h00, 8'hC3, 1'b1}, '{1'b0, 16'hFFFE, 8'h00, 8'h01, 1'b1}};
   host_slave_port dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .standby(standby), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
      .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit),
      .chan1_select_n(s1), .chan2_select_n(s2), .command_data_line(cd), .host_read_strobe_n(rdn),
      .host_write_strobe_n(wrn), .host_data_bus_in(bus), .host_data_bus_out(hout),
      .host_data_bus_oe_n(oe_n), .chan1_input_full_irq(irq1), .chan2_input_full_irq(irq2),
      .fast_gate_enable(fge), .host_port_enable(hpe));
   host_model host (.clk_sys(clk_sys), .dev_out(hout), .dev_oe_n(oe_n), .sel1_n(s1), .sel2_n(s2),
      .cmd(cd), .rd_n(rdn), .wr_n(wrn), .bus(bus));
   always #20 clk_sys = ~clk_sys;
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         results();
      end
   end
   task automatic check(input string nm, input logic [7:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // One-cycle strobe; the answer stands one cycle and is taken at the next fall
   task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rq,
                      output logic rh);
      @(negedge clk_sys);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = w;
      cpu_rd = !w;
      @(negedge clk_sys);
      rq = cpu_rdata;
      rh = cpu_hit;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
   endtask : cpu
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] rq;
      logic       rh;
      cpu(1'b0, a, 8'h00, rq, rh);
      check("rdata", rq, e);
   endtask : rd
   initial begin
      repeat (16) @(negedge clk_sys);
      reset_n = 1'b1;
      check("enable", {7'h00, hpe}, 8'h00);
      check("gate", {7'h00, fge}, 8'h00);
      check("oe_n", {7'h00, oe_n}, 8'h01);
      foreach (rows[i]) begin
         cpu(rows[i].w, rows[i].a, rows[i].d, q, h);
         if (!rows[i].w) begin
            check("hit", {7'h00, h}, {7'h00, rows[i].h});
            if (rows[i].h) check("rdata", q, rows[i].e);
         end
      end
      host.access(1'b0, 1'b1, 1'b1, 8'h5A, q);
      rd(16'hFFF6, 8'h0B);
      check("irq1", {7'h00, irq1}, 8'h01);
      check("gate", {7'h00, fge}, 8'h01);
      host.access(1'b0, 1'b0, 1'b0, 8'h00, q);
      check("chan1_output", q, 8'h3C);
      host.access(1'b0, 1'b1, 1'b0, 8'h00, q);
      check("chan1_status", q, 8'h0A);
      rd(16'hFFF4, 8'h5A);
      rd(16'hFFF6, 8'h08);
      check("irq1", {7'h00, irq1}, 8'h00);
      host.access(1'b1, 1'b0, 1'b1, 8'h96, q);
      rd(16'hFFFE, 8'h03);
      check("irq2", {7'h00, irq2}, 8'h01);
      cpu(1'b1, 16'hFFF0, 8'h03, q, h);
      rd(16'hFFF0, 8'hFB);
      check("irq2", {7'h00, irq2}, 8'h00);
      rd(16'hFFFC, 8'h96);
      cpu(1'b1, 16'hFFFC, 8'h00, q, h);
      rd(16'hFFFC, 8'h96);
      host.access(1'b1, 1'b0, 1'b0, 8'h00, q);
      check("chan2_output", q, 8'hC3);
      rd(16'hFFFE, 8'h00);
      // Host write while the port is off must leave both registers alone
      cpu(1'b1, 16'hFFC4, 8'h01, q, h);
      host.access(1'b0, 1'b0, 1'b1, 8'h77, q);
      cpu(1'b1, 16'hFFC4, 8'h03, q, h);
      rd(16'hFFF4, 8'h5A);
      rd(16'hFFF6, 8'h08);
      @(negedge clk_sys);
      standby = 1'b1;
      @(negedge clk_sys);
      standby = 1'b0;
      check("enable", {7'h00, hpe}, 8'h00);
      check("gate", {7'h00, fge}, 8'h00);
      rd(16'hFFC4, 8'h09);
      cpu(1'b1, 16'hFFC4, 8'h03, q, h);
      rd(16'hFFF0, 8'hF8);
      rd(16'hFFF6, 8'h00);
      results();
   end
endmodule : testbench
`default_nettype wire
